// *** hw/port_pin_function_mux.sv ***
// Implementation choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none

// How it works
// (R1) open-drain select makes uart transmit pin open-drain
// (R2) port 1 upper pins pulled up only as inputs
// (R3) port 3 pin 3 pulled up only as input
// (R4) port 3 pin 7 pulled up only as input
// (R5) software keeps pin mode reserved bit zero
// (R6) software keeps pulse control zero outside pulse mode
// (R7) timer a pin feeds timer and irq1
// (R8) pin select picks p1_5 or p1_7 for timer a
// (R9) subclock running: buffer and feedback resistor on
// (R10) resistor-off bit: buffer on, resistor disconnected
// (R11) stop bit: buffer off, resistor per its bit
// (R12) running buffer accepts external clock on input pin
// (R13) subclock pins oscillator function from reset
// (R14) select cleared: subclock pins become plain port
// (R15) p1_6: comparator, then uart clock out/in
// (R16) p3_7: timer a out, then timer f out11
// (R17) p3_3: timer f out10 drives, else feeds input
module port_pin_function_mux (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [pin_mux_pkg::ADDR_W-1:0] paddr,
    input wire logic [pin_mux_pkg::DATA_W-1:0] pwdata,
    input wire logic [pin_mux_pkg::STRB_W-1:0] pstrb,
    output logic [pin_mux_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire pin_mux_pkg::periph_drive_t periph_drive,
    output pin_mux_pkg::periph_sense_t periph_sense,
    output pin_mux_pkg::osc_ctrl_t osc_ctrl,
    input wire logic [pin_mux_pkg::NUM_PINS-1:0] pin_in,
    output logic [pin_mux_pkg::NUM_PINS-1:0] pin_out,
    output logic [pin_mux_pkg::NUM_PINS-1:0] pin_oe,
    output logic [pin_mux_pkg::NUM_PINS-1:0] pin_pullup
);
    import pin_mux_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // bus decode
    logic [DATA_W-1:0] regs_reg [NUM_RW]; // control registers
    logic [2:0] word_index; // register index from address
    logic addr_mapped; // address hits a register
    logic setup_phase; // first cycle of a transfer
    logic write_access; // write takes effect this edge

    assign word_index = paddr[4:2];
    assign addr_mapped = (paddr[1:0] == WORD_ALIGN) && (paddr <= OFS_PIN_STATUS);
    assign setup_phase = psel && !penable;
    assign write_access = psel && penable && pwrite && addr_mapped;
    // zero wait states: every access completes in its first access cycle
    assign pready = 1'b1;

    ////////////////////////////////////////////////////////////////////////////
    // writable register bank, one entry per register
    genvar gi;
    generate
        for (gi = 0; gi < NUM_RW; gi++) begin : g_reg
            logic [DATA_W-1:0] reg_next; // next register value
            logic [DATA_W-1:0] lane_mask; // bytes selected by pstrb

            // byte-lane merge of write data under the writable mask
            always_comb begin
                lane_mask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
                reg_next = regs_reg[gi];
                if (write_access && (word_index == 3'(gi))) begin
                    reg_next = (regs_reg[gi] & ~(lane_mask & RW_MASK[gi]))
                             | (pwdata & lane_mask & RW_MASK[gi]);
                end
            end

            // subclock select resets to one, giving oscillator pins
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    regs_reg[gi] <= RW_RESET[gi]; // R13
                end else begin
                    regs_reg[gi] <= reg_next;
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // pin input synchronisers
    logic [NUM_PINS-1:0] meta_reg; // first stage, read only by second stage
    logic [NUM_PINS-1:0] pin_sync_reg; // synchronised pin levels

    // two flops before any logic sees a pin
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_reg <= '0;
            pin_sync_reg <= '0;
        end else begin
            meta_reg <= pin_in;
            pin_sync_reg <= meta_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // field views
    logic [DATA_W-1:0] dir_w; // direction bits
    logic [DATA_W-1:0] data_w; // port output latches
    logic [DATA_W-1:0] pu_w; // pull-up controls
    logic [DATA_W-1:0] uart_w; // uart fields
    logic [DATA_W-1:0] ta_w; // timer a fields
    logic [DATA_W-1:0] tf_w; // timer f / comparator fields
    logic [DATA_W-1:0] clk_w; // subclock fields
    logic [2:0] serial_mode_field; // uart mode
    logic [2:0] timer_a_mode_field; // timer a mode
    logic uart_active; // uart enabled in any mode
    logic ta_in_mode; // timer a uses its pin as input
    logic ta_pulse_mode; // timer a drives its pin

    assign dir_w = regs_reg[REG_DIRECTION];
    assign data_w = regs_reg[REG_PORT_DATA];
    assign pu_w = regs_reg[REG_PULLUP];
    assign uart_w = regs_reg[REG_UART];
    assign ta_w = regs_reg[REG_TIMER_A];
    assign tf_w = regs_reg[REG_TIMER_F];
    assign clk_w = regs_reg[REG_CLOCK];
    assign serial_mode_field = uart_w[SERIAL_MODE_LSB +: 3];
    assign timer_a_mode_field = ta_w[TA_MODE_LSB +: 3];
    assign uart_active = serial_mode_field != SERIAL_OFF;
    // input use needs a counting mode and the pulse control bit clear
    assign ta_in_mode = (timer_a_mode_field != TA_MODE_TIMER)
                     && (timer_a_mode_field != TA_MODE_PULSE)
                     && !ta_w[TA_PULSE_POL]; // R8 R6
    assign ta_pulse_mode = timer_a_mode_field == TA_MODE_PULSE;

    ////////////////////////////////////////////////////////////////////////////
    // pin function selection
    logic [NUM_PINS-1:0] out_next; // next pin level
    logic [NUM_PINS-1:0] oe_next; // next pin enable
    logic [NUM_PINS-1:0] pu_next; // next pull-up enable
    periph_sense_t sense_next; // next peripheral inputs
    osc_ctrl_t osc_next; // next oscillator controls
    logic ta_pin_is_p15; // timer a routed to p1_5
    logic ta_pin_level; // level on the selected timer a pin
    logic ta_pin_input; // selected timer a pin is an input
    logic sub_sel; // subclock pin function chosen

    always_comb begin
        ta_pin_is_p15 = ta_w[TA_PIN_SEL]; // R8
        sub_sel = clk_w[SUBCLK_PIN_SEL];
        out_next = '0;
        oe_next = '0;
        pu_next = '0;
        sense_next = '0;
        osc_next = '0;

        // p1_4: uart transmit or plain port
        if (uart_active) begin
            if (uart_w[OPEN_DRAIN_SEL]) begin
                out_next[PIN_P1_4] = 1'b0; // R1
                oe_next[PIN_P1_4] = !periph_drive.uart_tx; // R1
            end else begin
                out_next[PIN_P1_4] = periph_drive.uart_tx;
                oe_next[PIN_P1_4] = 1'b1;
            end
        end else begin
            out_next[PIN_P1_4] = data_w[P1_BASE + 4];
            oe_next[PIN_P1_4] = dir_w[P1_BASE + 4];
            pu_next[PIN_P1_4] = pu_w[PU_P1_HIGH_NIBBLE] && !dir_w[P1_BASE + 4]; // R2
        end

        // p1_5 and p1_7: timer a output in pulse mode on the selected pin
        if (ta_pulse_mode && ta_pin_is_p15) begin
            out_next[PIN_P1_5] = periph_drive.timer_a_out; // R8
            oe_next[PIN_P1_5] = 1'b1;
        end else begin
            out_next[PIN_P1_5] = data_w[P1_BASE + 5];
            oe_next[PIN_P1_5] = dir_w[P1_BASE + 5];
            pu_next[PIN_P1_5] = pu_w[PU_P1_HIGH_NIBBLE] && !dir_w[P1_BASE + 5]; // R2
        end
        if (ta_pulse_mode && !ta_pin_is_p15) begin
            out_next[PIN_P1_7] = periph_drive.timer_a_out; // R8
            oe_next[PIN_P1_7] = 1'b1;
        end else begin
            out_next[PIN_P1_7] = data_w[P1_BASE + 7];
            oe_next[PIN_P1_7] = dir_w[P1_BASE + 7];
            pu_next[PIN_P1_7] = pu_w[PU_P1_HIGH_NIBBLE] && !dir_w[P1_BASE + 7]; // R2
        end

        // uart receive always watches p1_5 when it is an input
        sense_next.uart_rx = pin_sync_reg[PIN_P1_5] && !dir_w[P1_BASE + 5];

        // timer a input and irq1 follow the selected pin
        ta_pin_level = ta_pin_is_p15 ? pin_sync_reg[PIN_P1_5] : pin_sync_reg[PIN_P1_7];
        ta_pin_input = ta_pin_is_p15 ? !dir_w[P1_BASE + 5] : !dir_w[P1_BASE + 7];
        sense_next.timer_a_in = ta_in_mode && ta_pin_input && ta_pin_level; // R7 R8
        sense_next.ext_irq1 = ta_w[EXT_IRQ1_EN] && ta_pin_input && ta_pin_level; // R7

        // p1_6: comparator first, then uart clock
        if (tf_w[CMP2_OUT_EN]) begin
            out_next[PIN_P1_6] = periph_drive.comparator2_out; // R15
            oe_next[PIN_P1_6] = 1'b1;
        end else if (!uart_w[SERIAL_CLK_SRC] && (serial_mode_field == SERIAL_SYNC)) begin
            out_next[PIN_P1_6] = periph_drive.uart_clk_out; // R15
            oe_next[PIN_P1_6] = 1'b1;
        end else begin
            out_next[PIN_P1_6] = data_w[P1_BASE + 6];
            oe_next[PIN_P1_6] = dir_w[P1_BASE + 6];
            pu_next[PIN_P1_6] = pu_w[PU_P1_HIGH_NIBBLE] && !dir_w[P1_BASE + 6]; // R2
            sense_next.uart_clk_in = uart_w[SERIAL_CLK_SRC] && !dir_w[P1_BASE + 6]
                                  && pin_sync_reg[PIN_P1_6]; // R15
        end

        // p3_3: timer f output 10 overrides direction
        if (tf_w[TF_OUT10_BIT]) begin
            out_next[PIN_P3_3] = periph_drive.timer_f_out10; // R17
            oe_next[PIN_P3_3] = 1'b1;
        end else begin
            out_next[PIN_P3_3] = data_w[P3_BASE + 3];
            oe_next[PIN_P3_3] = dir_w[P3_BASE + 3];
            pu_next[PIN_P3_3] = pu_w[PU_P3_LOW_PIN] && !dir_w[P3_BASE + 3]; // R3
            sense_next.timer_f_in = !dir_w[P3_BASE + 3] && pin_sync_reg[PIN_P3_3]; // R17
        end

        // p3_7: timer a output, then timer f output 11
        if (tf_w[TA_OUT_PIN_SEL] && ta_w[TA_OUT_ENABLE]) begin
            out_next[PIN_P3_7] = periph_drive.timer_a_out; // R16
            oe_next[PIN_P3_7] = 1'b1;
        end else if (tf_w[TF_OUT_PIN_SEL] && tf_w[TF_OUT11_BIT]) begin
            out_next[PIN_P3_7] = periph_drive.timer_f_out11; // R16
            oe_next[PIN_P3_7] = 1'b1;
        end else begin
            out_next[PIN_P3_7] = data_w[P3_BASE + 7];
            oe_next[PIN_P3_7] = dir_w[P3_BASE + 7]; // R16
            pu_next[PIN_P3_7] = pu_w[PU_P3_HIGH_PIN] && !dir_w[P3_BASE + 7]; // R4
        end

        // subclock pins: oscillator when selected, plain port otherwise
        if (sub_sel) begin
            osc_next.buffer_on = !clk_w[SUBCLK_STOP]; // R9 R10 R11
            osc_next.feedback_on = !clk_w[FB_RES_OFF]; // R9 R10 R11
            // buffer on passes an external clock whatever the resistor
            sense_next.subclock_ext_clk = !clk_w[SUBCLK_STOP]
                                       && pin_sync_reg[PIN_SUB_IN]; // R12
        end else begin
            out_next[PIN_SUB_IN] = data_w[P4_BASE + 3]; // R14
            oe_next[PIN_SUB_IN] = dir_w[P4_BASE + 3]; // R14
            out_next[PIN_SUB_OUT] = data_w[P4_BASE + 4]; // R14
            oe_next[PIN_SUB_OUT] = dir_w[P4_BASE + 4]; // R14
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // registered pin and peripheral outputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_out <= '0;
            pin_oe <= '0;
            pin_pullup <= '0;
            periph_sense <= '0;
            // oscillator running out of reset
            osc_ctrl <= '{buffer_on: 1'b1, feedback_on: 1'b1}; // R13
        end else begin
            pin_out <= out_next;
            pin_oe <= oe_next;
            pin_pullup <= pu_next;
            periph_sense <= sense_next;
            osc_ctrl <= osc_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read data and error, captured in the setup cycle
    logic [DATA_W-1:0] rdata_next; // next read data
    logic slverr_next; // next error answer

    always_comb begin
        rdata_next = prdata;
        slverr_next = pslverr;
        if (setup_phase) begin
            rdata_next = '0;
            slverr_next = !addr_mapped;
            if (addr_mapped && !pwrite) begin
                if (word_index == 3'(REG_PIN_STATUS)) begin
                    rdata_next[STAT_PINS_LSB +: NUM_PINS] = pin_sync_reg;
                    rdata_next[STAT_BUF_ON] = osc_ctrl.buffer_on;
                    rdata_next[STAT_FB_ON] = osc_ctrl.feedback_on;
                end else begin
                    rdata_next = regs_reg[word_index];
                end
            end
        end
    end

    // hold answer through the access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= '0;
            pslverr <= 1'b0;
        end else begin
            prdata <= rdata_next;
            pslverr <= slverr_next;
        end
    end

endmodule
`default_nettype wire

// *** hw/pin_mux_pkg.sv ***
`default_nettype none
package pin_mux_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // bus geometry
    localparam int ADDR_W = 8; // byte address width
    localparam int DATA_W = 32; // apb data width
    localparam int STRB_W = 4; // byte lanes
    localparam int NUM_RW = 7; // software-writable registers
    localparam int NUM_PINS = 8; // shared pins handled here

    ////////////////////////////////////////////////////////////////////////////
    // register offsets
    localparam logic [ADDR_W-1:0] OFS_DIRECTION = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_PULLUP = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_UART = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_TIMER_A = 8'h0C;
    localparam logic [ADDR_W-1:0] OFS_TIMER_F = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_CLOCK = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_PORT_DATA = 8'h18;
    localparam logic [ADDR_W-1:0] OFS_PIN_STATUS = 8'h1C;
    localparam logic [1:0] WORD_ALIGN = 2'h0; // low address bits of a word

    // register indices (offset / 4)
    localparam int REG_DIRECTION = 0;
    localparam int REG_PULLUP = 1;
    localparam int REG_UART = 2;
    localparam int REG_TIMER_A = 3;
    localparam int REG_TIMER_F = 4;
    localparam int REG_CLOCK = 5;
    localparam int REG_PORT_DATA = 6;
    localparam int REG_PIN_STATUS = 7;

    // writable bits and reset values, by index
    localparam logic [DATA_W-1:0] RW_MASK [NUM_RW] = '{
        32'h0018_88F0, 32'h0000_00C8, 32'h0000_001F, 32'h0000_1177,
        32'h0000_3118, 32'h0000_0007, 32'h0018_88F0};
    localparam logic [DATA_W-1:0] RW_RESET [NUM_RW] = '{
        32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000,
        32'h0000_0000, 32'h0000_0001, 32'h0000_0000};

    ////////////////////////////////////////////////////////////////////////////
    // field positions: direction and port data share one layout
    localparam int P1_BASE = 0; // port 1 bit n at P1_BASE + n
    localparam int P3_BASE = 8; // port 3 bit n at P3_BASE + n
    localparam int P4_BASE = 16; // port 4 bit n at P4_BASE + n
    // pullup_control_low
    localparam int PU_P1_HIGH_NIBBLE = 3;
    localparam int PU_P3_LOW_PIN = 6;
    localparam int PU_P3_HIGH_PIN = 7;
    // uart_zero_control / uart_zero_mode_reg
    localparam int SERIAL_MODE_LSB = 0; // 3-bit serial_mode_field
    localparam int SERIAL_CLK_SRC = 3; // 1: external clock
    localparam int OPEN_DRAIN_SEL = 4;
    // timer_a_mode_reg / timer_a_io_control / pin_mode_reg
    localparam int TA_MODE_LSB = 0; // 3-bit timer_a_mode_field
    localparam int TA_PIN_SEL = 4; // 1: p1_5, 0: p1_7
    localparam int TA_PULSE_POL = 5;
    localparam int TA_OUT_ENABLE = 6;
    localparam int EXT_IRQ1_EN = 8;
    localparam int PIN_MODE_RSVD = 12; // must be kept at zero by software
    // timer_f_output_ctrl / comparator_mode_reg / pin_select_two / four
    localparam int TF_OUT10_BIT = 3;
    localparam int TF_OUT11_BIT = 4;
    localparam int CMP2_OUT_EN = 8;
    localparam int TA_OUT_PIN_SEL = 12;
    localparam int TF_OUT_PIN_SEL = 13;
    // clock_mode_reg_zero / clock_mode_reg_one
    localparam int SUBCLK_PIN_SEL = 0;
    localparam int SUBCLK_STOP = 1;
    localparam int FB_RES_OFF = 2;
    // pin status
    localparam int STAT_PINS_LSB = 0;
    localparam int STAT_BUF_ON = 8;
    localparam int STAT_FB_ON = 9;

    // pin vector positions
    localparam int PIN_P1_4 = 0;
    localparam int PIN_P1_5 = 1;
    localparam int PIN_P1_6 = 2;
    localparam int PIN_P1_7 = 3;
    localparam int PIN_P3_3 = 4;
    localparam int PIN_P3_7 = 5;
    localparam int PIN_SUB_IN = 6;
    localparam int PIN_SUB_OUT = 7;

    // mode encodings
    localparam logic [2:0] TA_MODE_TIMER = 3'h0;
    localparam logic [2:0] TA_MODE_PULSE = 3'h1;
    localparam logic [2:0] SERIAL_OFF = 3'h0;
    localparam logic [2:0] SERIAL_SYNC = 3'h1;

    ////////////////////////////////////////////////////////////////////////////
    // carriers
    typedef struct packed {
        logic uart_tx; // uart zero transmit data
        logic uart_clk_out; // uart zero internal clock
        logic comparator2_out; // comparator 2 result
        logic timer_a_out; // timer a output
        logic timer_f_out10; // timer f output 10
        logic timer_f_out11; // timer f output 11
    } periph_drive_t;

    typedef struct packed {
        logic uart_rx; // uart zero receive data
        logic uart_clk_in; // uart zero external clock
        logic timer_a_in; // timer a event input
        logic ext_irq1; // external interrupt 1 level
        logic timer_f_in; // timer f capture input
        logic subclock_ext_clk; // externally driven subclock
    } periph_sense_t;

    typedef struct packed {
        logic buffer_on; // oscillation buffer enable
        logic feedback_on; // on-chip feedback resistor enable
    } osc_ctrl_t;

endpackage
`default_nettype wire

// *** tb/port_pin_function_mux_checker.sv ***
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// port-side watcher: bus answers, pull-ups, subclock pins
module port_pin_function_mux_checker (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [pin_mux_pkg::ADDR_W-1:0] paddr,
    input wire logic [pin_mux_pkg::DATA_W-1:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire pin_mux_pkg::osc_ctrl_t osc_ctrl,
    input wire logic [pin_mux_pkg::NUM_PINS-1:0] pin_oe,
    input wire logic [pin_mux_pkg::NUM_PINS-1:0] pin_pullup
);
    import pin_mux_pkg::*;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // zero wait states
    pready_tied_a: assert property (pready) else $error("pready low");
    // unmapped or misaligned setup gives error and zero data
    bad_addr_err_a: assert property (psel && !penable && (paddr > 8'h1C || paddr[1:0] != 2'h0)
        |=> pslverr && prdata == 32'h0) else $error("no error on unmapped access");
    good_addr_ok_a: assert property (psel && !penable && paddr <= 8'h1C && paddr[1:0] == 2'h0
        |=> !pslverr) else $error("error on mapped access");
    // read data stands through the access cycle
    read_hold_a: assert property (psel && !penable ##1 psel && penable |=> $stable(prdata))
        else $error("read data moved");
    pullup_input_a: assert property ((pin_pullup & pin_oe) == 8'h00)
        else $error("pull-up on a driven pin");
    subclk_float_a: assert property (osc_ctrl.buffer_on || osc_ctrl.feedback_on
        |-> pin_oe[7:6] == 2'h0) else $error("subclock pin driven in oscillator mode");
    reset_osc_a: assert property ($rose(presetn) |-> osc_ctrl == 2'h3 && pin_oe == 8'h00)
        else $error("oscillator not selected after reset");
    // oscillator controls move only two edges after a clock register write
    osc_by_write_a: assert property ($changed(osc_ctrl)
        |-> $past(psel && penable && pwrite && paddr == OFS_CLOCK, 2))
        else $error("oscillator control changed without write");
endmodule

bind port_pin_function_mux port_pin_function_mux_checker i_port_pin_function_mux_checker (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .osc_ctrl(osc_ctrl), .pin_oe(pin_oe), .pin_pullup(pin_pullup));
`default_nettype wire

// *** tb/board_pin_model.sv ***
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// board side: resolves each pin from chip drive, board drive and pull-up
module board_pin_model (
    input wire logic pclk,
    input wire logic [pin_mux_pkg::NUM_PINS-1:0] pin_out,
    input wire logic [pin_mux_pkg::NUM_PINS-1:0] pin_oe,
    input wire logic [pin_mux_pkg::NUM_PINS-1:0] pin_pullup,
    input wire logic [pin_mux_pkg::NUM_PINS-1:0] drive_val,
    input wire logic [pin_mux_pkg::NUM_PINS-1:0] drive_en,
    output logic [pin_mux_pkg::NUM_PINS-1:0] pin_in
);
    logic [pin_mux_pkg::NUM_PINS-1:0] last_reg = '0; // previous level, floats invert it

    // remember last level seen
    always_ff @(posedge pclk) begin
        last_reg <= pin_in;
    end

    // chip drive first, then board, then pull-up, else a floating toggle
    always_comb begin
        for (int i = 0; i < pin_mux_pkg::NUM_PINS; i++) begin
            pin_in[i] = pin_oe[i] ? pin_out[i] : drive_en[i] ? drive_val[i] :
                pin_pullup[i] ? 1'b1 : ~last_reg[i];
        end
    end
endmodule
`default_nettype wire

// *** tb/port_pin_function_mux_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none

module port_pin_function_mux_tb_top;
    import pin_mux_pkg::*;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [3:0] pstrb = 4'hF; // full words only
    logic pready, pslverr, er;
    periph_drive_t periph_drive = '0;
    periph_sense_t periph_sense;
    osc_ctrl_t osc_ctrl;
    logic [7:0] pin_in, pin_out, pin_oe, pin_pullup, drive_val = 8'h00, drive_en = 8'h00;
    logic [2:0] cfg [4] = '{3'h1, 3'h5, 3'h3, 3'h7}; // select, stop, resistor-off
    int fails = 0, samples_checked = 0;

    always #20 pclk = ~pclk;

    port_pin_function_mux i_port_pin_function_mux (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .periph_drive(periph_drive), .periph_sense(periph_sense), .osc_ctrl(osc_ctrl),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup(pin_pullup));
    board_pin_model i_board_pin_model (.pclk(pclk), .pin_out(pin_out), .pin_oe(pin_oe),
        .pin_pullup(pin_pullup), .drive_val(drive_val), .drive_en(drive_en), .pin_in(pin_in));

    ////////////////////////////////////////////////////////////////////////////
    // one apb transfer, held until pready
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // settle, then sample off the edge
    task wait_n(input int n);
        repeat (n) @(posedge pclk);
        #1;
    endtask

    // write, let pins follow
    task wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
        wait_n(2);
    endtask

    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task results;
        $display("checks %0d failures %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // hang guard
    initial begin
        repeat (5000) @(posedge pclk);
        fails++;
        results();
    end

    // main sequence; timer a writes keep reserved and polarity bits zero
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        wait_n(1);
        chk("osc after reset", osc_ctrl, 2'h3);
        apb(1'b0, OFS_CLOCK, 32'h0);
        chk("clock reg reset", rd, RW_RESET[REG_CLOCK]);
        apb(1'b0, 8'h20, 32'h0);
        chk("unmapped error", er, 1'b1);
        chk("unmapped data", rd, 32'h0);
        apb(1'b1, OFS_DIRECTION, 32'hFFFF_FFFF);
        apb(1'b0, OFS_DIRECTION, 32'h0);
        chk("direction mask", rd, RW_MASK[REG_DIRECTION]);
        // pull-ups only on inputs
        apb(1'b1, OFS_DIRECTION, 32'h0);
        wr(OFS_PULLUP, 32'hC8);
        chk("pullup inputs", pin_pullup, 8'h3F);
        wr(OFS_DIRECTION, 32'h8010);
        chk("pullup outputs", pin_pullup, 8'h1E);
        wr(OFS_DIRECTION, 32'h0);
        wr(OFS_PULLUP, 32'h0);
        // uart transmit open-drain and push-pull, clock pin priority
        periph_drive.uart_clk_out <= 1'b1;
        wr(OFS_UART, 32'h11);
        chk("open drain low", {pin_oe[0], pin_out[0]}, 2'b10);
        periph_drive.uart_tx <= 1'b1;
        wait_n(2);
        chk("open drain high", pin_oe[0], 1'b0);
        wr(OFS_UART, 32'h01);
        chk("push pull high", {pin_oe[0], pin_out[0]}, 2'b11);
        chk("uart clock out", {pin_oe[2], pin_out[2]}, 2'b11);
        wr(OFS_TIMER_F, 32'h100);
        chk("comparator wins", {pin_oe[2], pin_out[2]}, 2'b10);
        wr(OFS_TIMER_F, 32'h0);
        drive_en <= 8'h0E;
        drive_val <= 8'h06;
        wr(OFS_UART, 32'h08);
        wait_n(3);
        chk("uart clock in", periph_sense.uart_clk_in, 1'b1);
        wr(OFS_UART, 32'h0);
        // timer a input pin choice and irq1
        wr(OFS_TIMER_A, 32'h112);
        wait_n(3);
        chk("timer a on p1_5", {periph_sense.uart_rx, periph_sense.timer_a_in,
            periph_sense.ext_irq1}, 3'b111);
        wr(OFS_TIMER_A, 32'h102);
        wait_n(3);
        chk("timer a on p1_7", {periph_sense.timer_a_in, periph_sense.ext_irq1}, 2'b00);
        drive_val <= 8'h08;
        wr(OFS_TIMER_A, 32'h001);
        wait_n(3);
        chk("pulse mode no input", periph_sense.timer_a_in, 1'b0);
        wr(OFS_TIMER_A, 32'h0);
        // timer f pins and timer a output pin
        periph_drive.timer_f_out10 <= 1'b1;
        wr(OFS_TIMER_F, 32'h8);
        chk("timer f out10", {pin_oe[4], pin_out[4]}, 2'b11);
        drive_en <= 8'h10;
        drive_val <= 8'h10;
        wr(OFS_TIMER_F, 32'h0);
        wait_n(3);
        chk("timer f input", periph_sense.timer_f_in, 1'b1);
        periph_drive.timer_a_out <= 1'b1;
        wr(OFS_TIMER_F, 32'h1000);
        wr(OFS_TIMER_A, 32'h40);
        chk("timer a out", {pin_oe[5], pin_out[5]}, 2'b11);
        wr(OFS_TIMER_A, 32'h0);
        wr(OFS_TIMER_F, 32'h2010);
        chk("timer f out11", {pin_oe[5], pin_out[5]}, 2'b10);
        wr(OFS_TIMER_F, 32'h0);
        // subclock buffer and feedback resistor table
        for (int i = 0; i < 4; i++) begin
            wr(OFS_CLOCK, {29'h0, cfg[i]});
            chk("osc control", osc_ctrl, {~cfg[i][1], ~cfg[i][2]});
        end
        drive_en <= 8'hC0;
        drive_val <= 8'h40;
        wr(OFS_CLOCK, 32'h5);
        wait_n(3);
        chk("external subclock", periph_sense.subclock_ext_clk, 1'b1);
        apb(1'b0, OFS_PIN_STATUS, 32'h0);
        chk("pin status", rd[9:6], 4'h5);
        // back to port function
        drive_en <= 8'h00;
        apb(1'b1, OFS_PORT_DATA, 32'h8_0000);
        wr(OFS_DIRECTION, 32'h8_0000);
        wr(OFS_CLOCK, 32'h0);
        chk("port function", {osc_ctrl, pin_oe[6], pin_out[6]}, 4'b0011);
        // second reset returns oscillator function
        presetn <= 1'b0;
        wait_n(2);
        presetn <= 1'b1;
        wait_n(1);
        chk("osc after rereset", {osc_ctrl, pin_oe[7:6]}, 4'b1100);
        results();
    end
endmodule
`default_nettype wire
